// ### hdl/i2cas_params.svh
`ifndef I2CAS_PARAMS_SVH
`define I2CAS_PARAMS_SVH

`define I2CAS_ADDR_CTRL    4'h0
`define I2CAS_ADDR_STATUS  4'h1
`define I2CAS_ADDR_MASK    4'h2
`define I2CAS_ADDR_BUF     4'h3
`define I2CAS_ADDR_BRG     4'h4

`define I2CAS_CTRL_ACK_EN   0
`define I2CAS_CTRL_ACK_DATA 1
`define I2CAS_CTRL_STOPEN  2

`define I2CAS_ST_STOPDET   0
`define I2CAS_ST_WRCOLL    1
`define I2CAS_ST_PORTIF    2
`define I2CAS_ST_ACKDONE   3

`define I2CAS_BRG_RESET    8'h09

`endif

// ### hdl/i2cas_pkg.sv
package i2cas_pkg;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_ACK_LOW,
        SEQ_ACK_WAIT_HI,
        SEQ_ACK_HIGH,
        SEQ_STOP_SDA,
        SEQ_STOP_SCL,
        SEQ_STOP_REL,
        SEQ_STOP_DONE
    } i2cas_state_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } i2cas_req_type;

    typedef struct packed {
        logic scl_o;
        logic scl_oe_n;
        logic sda_o;
        logic sda_oe_n;
    } i2cas_pins_type;

endpackage : i2cas_pkg

// ### hdl/i2cas_sequencer.sv
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ns
`include "i2cas_params.svh"

module i2cas_sequencer
(
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    // Register port
    input  wire i2cas_pkg::i2cas_req_type req,
    output logic [7:0]                   rdata,
    // Bus pins
    input  wire logic                    scl_i,
    input  wire logic                    sda_i,
    output i2cas_pkg::i2cas_pins_type    pins,
    // Interrupt
    output logic                         irq
);
    import i2cas_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic       scl_s;
    logic       sda_s;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
        end
        else
        begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
        end
    end

    assign scl_s = scl_sync_q[1];
    assign sda_s = sda_sync_q[1];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    i2cas_state_type state_q;
    logic            ack_sequence_enable_q;
    logic            ack_data_value_q;
    logic            stop_sequence_enable_q;
    logic [7:0]      brg_reload_q;
    logic [7:0]      transfer_buffer_q;
    logic [3:0]      status_q;
    logic [3:0]      mask_q;
    logic [7:0]      brg_cnt_q;
    logic            brg_run_q;
    logic            brg_tick;
    logic            busy;
    logic            wr_ctrl;
    logic            wr_buf;
    logic            wr_stat;
    logic            ev_stopdet;
    logic            ev_write_collision_flag;
    logic            ev_portif;
    logic            ev_ackdone;
    logic [3:0]      ev_set;

    assign busy    = (state_q != SEQ_IDLE);
    assign wr_ctrl = req.wr && (req.addr == `I2CAS_ADDR_CTRL);
    assign wr_buf  = req.wr && (req.addr == `I2CAS_ADDR_BUF);
    assign wr_stat = req.wr && (req.addr == `I2CAS_ADDR_STATUS);

    // ------------------------------------------------------------
    // Baud rate generator
    // ------------------------------------------------------------
    // Tick marks the end of one rollover period; reload restarts it
    logic brg_load;

    assign brg_tick = brg_run_q && (brg_cnt_q == 8'h00);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            brg_cnt_q <= 8'h00;
        end
        else if (brg_load || brg_tick)
        begin
            brg_cnt_q <= brg_reload_q;
        end
        else if (brg_run_q)
        begin
            brg_cnt_q <= brg_cnt_q - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    logic scl_low_q;
    logic sda_low_q;

    always_comb
    begin
        brg_load = 1'b0;
        case (state_q)
            SEQ_IDLE:        brg_load = 1'b1;
            SEQ_ACK_WAIT_HI: brg_load = 1'b1;
            SEQ_STOP_SDA:    brg_load = 1'b1;
            SEQ_STOP_REL:    brg_load = !sda_low_q && sda_s && scl_s;
            default:         brg_load = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q    <= SEQ_IDLE;
            brg_run_q  <= 1'b0;
            scl_low_q  <= 1'b1;
            sda_low_q  <= 1'b0;
            ev_ackdone <= 1'b0;
            ev_stopdet <= 1'b0;
            ev_portif  <= 1'b0;
        end
        else
        begin
            ev_ackdone <= 1'b0;
            ev_stopdet <= 1'b0;
            ev_portif  <= 1'b0;
            case (state_q)
                SEQ_IDLE:
                begin
                    // SCL keeps its level: low after reset or an acknowledge, free after a stop
                    if (wr_ctrl && req.wdata[`I2CAS_CTRL_ACK_EN])
                    begin
                        sda_low_q <= ~req.wdata[`I2CAS_CTRL_ACK_DATA];
                        brg_run_q <= 1'b1;
                        state_q   <= SEQ_ACK_LOW;
                    end
                    else if (wr_ctrl && req.wdata[`I2CAS_CTRL_STOPEN])
                    begin
                        sda_low_q <= 1'b1;
                        state_q   <= SEQ_STOP_SDA;
                    end
                end
                SEQ_ACK_LOW:
                begin
                    if (brg_tick)
                    begin
                        scl_low_q <= 1'b0;
                        brg_run_q <= 1'b0;
                        state_q   <= SEQ_ACK_WAIT_HI;
                    end
                end
                SEQ_ACK_WAIT_HI:
                begin
                    // Slave may stretch; wait for SCL to really rise
                    if (scl_s)
                    begin
                        brg_run_q <= 1'b1;
                        state_q   <= SEQ_ACK_HIGH;
                    end
                end
                SEQ_ACK_HIGH:
                begin
                    if (brg_tick)
                    begin
                        scl_low_q  <= 1'b1;
                        brg_run_q  <= 1'b0;
                        ev_ackdone <= 1'b1;
                        state_q    <= SEQ_IDLE;
                    end
                end
                SEQ_STOP_SDA:
                begin
                    if (!sda_s)
                    begin
                        brg_run_q <= 1'b1;
                        state_q   <= SEQ_STOP_SCL;
                    end
                end
                SEQ_STOP_SCL:
                begin
                    if (brg_tick)
                    begin
                        scl_low_q <= 1'b0;
                        state_q   <= SEQ_STOP_REL;
                    end
                end
                SEQ_STOP_REL:
                begin
                    if (brg_tick)
                    begin
                        sda_low_q <= 1'b0;
                    end
                    if (!sda_low_q && sda_s && scl_s)
                    begin
                        ev_stopdet <= 1'b1;
                        state_q    <= SEQ_STOP_DONE;
                    end
                end
                SEQ_STOP_DONE:
                begin
                    if (brg_tick)
                    begin
                        ev_portif <= 1'b1;
                        brg_run_q <= 1'b0;
                        state_q   <= SEQ_IDLE;
                    end
                end
                default:
                begin
                    state_q <= SEQ_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------
    // Enables read back high for the whole sequence, cleared by hardware
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ack_sequence_enable_q  <= 1'b0;
            ack_data_value_q       <= 1'b0;
            stop_sequence_enable_q <= 1'b0;
            brg_reload_q           <= `I2CAS_BRG_RESET;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ack_data_value_q <= req.wdata[`I2CAS_CTRL_ACK_DATA];
            end
            if (wr_ctrl && !busy && req.wdata[`I2CAS_CTRL_ACK_EN])
            begin
                ack_sequence_enable_q <= 1'b1;
            end
            else if (state_q == SEQ_ACK_HIGH && brg_tick)
            begin
                ack_sequence_enable_q <= 1'b0;
            end
            if (wr_ctrl && !busy && !req.wdata[`I2CAS_CTRL_ACK_EN]
                && req.wdata[`I2CAS_CTRL_STOPEN])
            begin
                stop_sequence_enable_q <= 1'b1;
            end
            else if (state_q == SEQ_STOP_DONE && brg_tick)
            begin
                stop_sequence_enable_q <= 1'b0;
            end
            if (req.wr && req.addr == `I2CAS_ADDR_BRG)
            begin
                brg_reload_q <= req.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Transfer buffer
    // ------------------------------------------------------------
    assign ev_write_collision_flag = wr_buf && busy;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            transfer_buffer_q <= 8'h00;
        end
        else if (wr_buf && !busy)
        begin
            transfer_buffer_q <= req.wdata;
        end
    end

    // ------------------------------------------------------------
    // Status, mask, interrupt
    // ------------------------------------------------------------
    // Sticky bits: a set in the clearing cycle wins
    assign ev_set = {ev_ackdone, ev_portif, ev_write_collision_flag, ev_stopdet};

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            status_q <= 4'h0;
        end
        else
        begin
            status_q <= (status_q & ~(wr_stat ? req.wdata[3:0] : 4'h0)) | ev_set;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mask_q <= 4'h0;
        end
        else if (req.wr && req.addr == `I2CAS_ADDR_MASK)
        begin
            mask_q <= req.wdata[3:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(((status_q & ~(wr_stat ? req.wdata[3:0] : 4'h0)) | ev_set) & mask_q);
        end
    end

    // ------------------------------------------------------------
    // Pins and read data
    // ------------------------------------------------------------
    // Open drain: only ever drive low, enable active low
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pins <= '{scl_o: 1'b0, scl_oe_n: 1'b1, sda_o: 1'b0, sda_oe_n: 1'b1};
        end
        else
        begin
            pins.scl_o    <= 1'b0;
            pins.sda_o    <= 1'b0;
            pins.scl_oe_n <= ~scl_low_q;
            pins.sda_oe_n <= ~sda_low_q;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata <= 8'h00;
        end
        else if (req.rd)
        begin
            case (req.addr)
                `I2CAS_ADDR_CTRL:   rdata <= {5'h00, stop_sequence_enable_q,
                                              ack_data_value_q, ack_sequence_enable_q};
                `I2CAS_ADDR_STATUS: rdata <= {4'h0, status_q};
                `I2CAS_ADDR_MASK:   rdata <= {4'h0, mask_q};
                `I2CAS_ADDR_BUF:    rdata <= transfer_buffer_q;
                `I2CAS_ADDR_BRG:    rdata <= brg_reload_q;
                default:            rdata <= 8'h00;
            endcase
        end
        else
        begin
            rdata <= 8'h00;
        end
    end

endmodule : i2cas_sequencer

// ### sim/i2cas_slave_model.sv
`timescale 1ns/1ns

module i2cas_slave_model
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Master drive, low = pull line low
    input  wire logic       scl_oe_n,
    input  wire logic       sda_oe_n,
    // Cycles the slave holds SCL low after each release
    input  wire logic [7:0] stretch,
    // Wired line levels, pull-up on both
    output logic            scl,
    output logic            sda
);
    logic [7:0] cnt_q;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            cnt_q <= 8'h00;
        else if (!scl_oe_n)
            cnt_q <= 8'h00;
        else if (cnt_q < stretch)
            cnt_q <= cnt_q + 8'h01;
    end

    assign scl = scl_oe_n & (cnt_q >= stretch);
    // Slave leaves SDA to the master in these sequences
    assign sda = sda_oe_n;
endmodule : i2cas_slave_model

// ### sim/i2cas_seq_asserts.sv
`timescale 1ns/1ns
`include "i2cas_params.svh"

module i2cas_seq_asserts
(
    // Watched ports
    input wire logic                     core_clk,
    input wire logic                     rst,
    input wire i2cas_pkg::i2cas_req_type req,
    input wire logic [7:0]               rdata,
    input wire logic                     scl_i,
    input wire logic                     sda_i,
    input wire i2cas_pkg::i2cas_pins_type pins,
    input wire logic                     irq
);
    import i2cas_pkg::*;
    logic [7:0] hi_q;
    logic [7:0] lo_q;
    logic [7:0] mask_q;
    logic [8:0] per_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Saturating run lengths of SCL drive; high starts full so reset exit is clean
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            hi_q <= 8'hFF;
            lo_q <= 8'h00;
        end
        else
        begin
            hi_q <= !pins.scl_oe_n ? 8'h00 : (hi_q == 8'hFF ? hi_q : hi_q + 8'h01);
            lo_q <= pins.scl_oe_n ? 8'h00 : (lo_q == 8'hFF ? lo_q : lo_q + 8'h01);
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mask_q <= 8'h00;
            per_q  <= {1'b0, `I2CAS_BRG_RESET} + 9'h001;
        end
        else if (req.wr && req.addr == `I2CAS_ADDR_MASK)
            mask_q <= req.wdata;
        else if (req.wr && req.addr == `I2CAS_ADDR_BRG)
            per_q <= {1'b0, req.wdata} + 9'h001;
    end

    a_rdata_idle: assert property (!$past(req.rd) |-> rdata == 8'h00)
        else $error("rdata not zero outside read slot");
    a_pins_open_drain: assert property (pins.scl_o == 1'b0 && pins.sda_o == 1'b0)
        else $error("pin output level not zero");
    a_sda_fall_low: assert property ($fell(pins.sda_oe_n) |-> !pins.scl_oe_n)
        else $error("SDA pulled low while SCL released");
    // SDA may rise with SCL low (not-acknowledge); with SCL free it is a stop
    a_sda_rise_high: assert property (($rose(pins.sda_oe_n) && pins.scl_oe_n)
        |=> pins.scl_oe_n [*8])
        else $error("SCL pulled low right after stop");
    a_stop_sda_gap: assert property (($rose(pins.sda_oe_n) && pins.scl_oe_n) |->
        {1'b0, hi_q} >= per_q && {1'b0, hi_q} <= per_q + 9'h003)
        else $error("SDA release not one period after SCL release");
    a_scl_high_min: assert property ($fell(pins.scl_oe_n) |-> {1'b0, hi_q} >= per_q)
        else $error("SCL high shorter than one period");
    a_scl_low_min: assert property ($rose(pins.scl_oe_n) |-> {1'b0, lo_q} >= per_q)
        else $error("SCL low shorter than one period");
    a_irq_masked: assert property (irq |-> $past(mask_q) != 8'h00)
        else $error("irq high with mask clear");
endmodule : i2cas_seq_asserts

bind i2cas_sequencer i2cas_seq_asserts u_chk
(
    .core_clk (core_clk),
    .rst      (rst),
    .req      (req),
    .rdata    (rdata),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .pins     (pins),
    .irq      (irq)
);

// ### sim/tb_top.sv
`timescale 1ns/1ns
`include "i2cas_params.svh"

module tb_top;
    import i2cas_pkg::*;
    logic            core_clk;
    logic            rst;
    i2cas_req_type   req;
    logic [7:0]      rdata;
    i2cas_pins_type  pins;
    logic            irq;
    logic            scl;
    logic            sda;
    logic [7:0]      stretch;
    logic [7:0]      v;
    int              n_mismatch;
    int              check_count;
    int              cyc;

    i2cas_sequencer u_dut
    (
        .core_clk (core_clk),
        .rst      (rst),
        .req      (req),
        .rdata    (rdata),
        .scl_i    (scl),
        .sda_i    (sda),
        .pins     (pins),
        .irq      (irq)
    );

    i2cas_slave_model u_slave
    (
        .core_clk (core_clk),
        .rst      (rst),
        .scl_oe_n (pins.scl_oe_n),
        .sda_oe_n (pins.sda_oe_n),
        .stretch  (stretch),
        .scl      (scl),
        .sda      (sda)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= {a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        req <= '0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        req <= {a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk);
        req <= '0;
        #1;
        d = rdata;
    endtask : rd

    task automatic wait_clear(input int b);
        logic [7:0] c;
        int         n;
        c = 8'hFF;
        n = 0;
        // Bounded poll so a stuck enable ends as a mismatch
        while (c[b] !== 1'b0 && n < 300)
        begin
            rd(`I2CAS_ADDR_CTRL, c);
            n++;
        end
        chk("ctrl_enable", 8'h00, {7'h00, c[b]});
    endtask : wait_clear

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial
    begin
        logic [7:0] rst_val [6];
        rst_val = '{8'h00, 8'h00, 8'h00, 8'h00, `I2CAS_BRG_RESET, 8'h00};
        req = '0;
        stretch = 8'h00;
        rst = 1'b1;
        n_mismatch = 0;
        check_count = 0;
        cyc = 0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        // Reset values, last entry is an unmapped address
        for (int i = 0; i < 6; i++)
        begin
            rd((i == 5) ? 4'h7 : i[3:0], v);
            chk("reset_value", rst_val[i], v);
        end
        wr(`I2CAS_ADDR_BUF, 8'h5A);
        rd(`I2CAS_ADDR_BUF, v);
        chk("buffer", 8'h5A, v);
        // Acknowledge with a stretching slave
        stretch = 8'h0C;
        wr(`I2CAS_ADDR_CTRL, 8'h01);
        wr(`I2CAS_ADDR_BUF, 8'hA5);
        rd(`I2CAS_ADDR_BUF, v);
        chk("buffer", 8'h5A, v);
        chk("sda_oe_n", 8'h00, {7'h00, pins.sda_oe_n});
        chk("scl_oe_n", 8'h00, {7'h00, pins.scl_oe_n});
        wait_clear(`I2CAS_CTRL_ACK_EN);
        rd(`I2CAS_ADDR_STATUS, v);
        chk("status", 8'h0A, v);
        chk("scl_oe_n", 8'h00, {7'h00, pins.scl_oe_n});
        chk("sda_oe_n", 8'h00, {7'h00, pins.sda_oe_n});
        wr(`I2CAS_ADDR_STATUS, 8'h08);
        rd(`I2CAS_ADDR_STATUS, v);
        chk("status", 8'h02, v);
        wr(`I2CAS_ADDR_STATUS, 8'h02);
        // Not-acknowledge on a shorter period
        stretch = 8'h00;
        wr(`I2CAS_ADDR_BRG, 8'h03);
        wr(`I2CAS_ADDR_CTRL, 8'h03);
        settle(3);
        chk("sda_oe_n", 8'h01, {7'h00, pins.sda_oe_n});
        wait_clear(`I2CAS_CTRL_ACK_EN);
        rd(`I2CAS_ADDR_STATUS, v);
        chk("status", 8'h08, v);
        wr(`I2CAS_ADDR_STATUS, 8'h08);
        // Stop with the port interrupt masked, then unmasked
        wr(`I2CAS_ADDR_CTRL, 8'h04);
        settle(3);
        chk("sda_oe_n", 8'h00, {7'h00, pins.sda_oe_n});
        wr(`I2CAS_ADDR_BUF, 8'hC3);
        rd(`I2CAS_ADDR_BUF, v);
        chk("buffer", 8'h5A, v);
        wait_clear(`I2CAS_CTRL_STOPEN);
        rd(`I2CAS_ADDR_STATUS, v);
        chk("status", 8'h07, v);
        chk("lines", 8'h03, {6'h00, scl, sda});
        chk("irq", 8'h00, {7'h00, irq});
        wr(`I2CAS_ADDR_MASK, 8'h04);
        settle(2);
        chk("irq", 8'h01, {7'h00, irq});
        wr(`I2CAS_ADDR_STATUS, 8'h07);
        settle(2);
        chk("irq", 8'h00, {7'h00, irq});
        rd(`I2CAS_ADDR_STATUS, v);
        chk("status", 8'h00, v);
        tally_and_finish();
    end
endmodule : tb_top
